// file: cpb_dev.sv
// Peripheral logic end of the core bus: arbitration, ordered data beats, snoop.
// Assumes one clk for both ends; the bus runs on bus_ce from the divider here.
// What this block does
// [RULE1] Width fixed 32 or 64 at power-up
// [RULE2] Every transaction carries 32-bit address, attributes
// [RULE3] 32-bit width: 8/16/24/32-bit single clock transfers
// [RULE4] 32-bit width: single, two or eight beats
// [RULE5] 32-bit noncached accesses use single/double beats
// [RULE6] 32-bit cache line moves as eight beats
// [RULE7] 64-bit width: 8 to 64-bit single clock transfers; 40, 48 and 56-bit sizes end in tea
// [RULE8] 64-bit: single or four beats, noncached single
// [RULE9] 64-bit cache line moves as four beats
// [RULE10] Address tenure overlaps earlier data tenure
// [RULE11] Address-only transactions carry no data tenure
// [RULE12] PCI memory accesses shown for snoop, if enabled
// [RULE13] Bus runs synchronous at a divided rate
// [RULE14] Nine control signal groups on the bus
// [RULE15] Data follows its address, in address order
`timescale 1ns/1ps
module cpb_dev #(
  parameter int BUS_DIV = `CPB_BUS_DIV,
  parameter int QD = `CPB_QDEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Width strap, sampled while in reset
  input wire logic strap_wide64,
  // Bus
  cpb_if.dev bus,
  // PCI snoop requests
  input wire logic snoop_en,
  input wire logic pci_req,
  input wire logic [31:0] pci_addr,
  input wire logic pci_wr,
  output logic pci_ack,
  // Memory side, one request per beat
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_be,
  output logic [63:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata,
  // Events
  output logic aonly_seen,
  output logic bus_err
);
  import cpb_pkg::*;
  localparam int PW = $clog2(QD);

  // ****************************************
  // Bus clock divider
  // ****************************************
  logic [7:0] div_ff, nxt_div;
  logic wide_ff;

  // Core side ratio is a plain divide of clk, so both ends stay in step
  always_comb begin
    nxt_div = (div_ff == 8'(BUS_DIV - 1)) ? 8'h0 : div_ff + 8'h1; // [RULE13]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff <= 8'h0;
      wide_ff <= strap_wide64; // [RULE1]
    end else begin
      div_ff <= nxt_div;
    end
  end

  assign bus.bus_ce = div_ff == 8'h0; // [RULE13]

  // ****************************************
  // Address tenure and snoop
  // ****************************************
  cpb_afsm_t a_ff, nxt_a;
  logic bg_ff, nxt_bg, aack_ff, nxt_aack, snp_ff, nxt_snp, snw_ff, nxt_snw;
  logic [31:0] sna_ff, nxt_sna;
  logic pack_ff, nxt_pack, aon_ff, nxt_aon, push, bad, full;
  logic [PW:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [3:0] lane, lanes, nbeats;
  logic [31:0] q_addr [QD];
  logic [3:0] q_sz [QD];
  logic [3:0] q_beats [QD];
  logic q_wr [QD];
  logic q_bst [QD];
  logic q_err [QD];

  assign full = (wp_ff - rp_ff) == (PW + 1)'(QD);
  assign lanes = wide_ff ? `CPB_LANES64 : `CPB_LANES32;
  assign lane = wide_ff ? {1'b0, bus.addr[2:0]} : {2'b00, bus.addr[1:0]};
  assign nbeats = cpb_beats(wide_ff, bus.tbst, bus.tsiz); // [RULE4] [RULE6] [RULE8] [RULE9]

  // Unsupported sizes, lane overruns, misaligned doublewords and bursts marked noncached or write-through end in tea
  always_comb begin
    bad = 1'b0;
    if (bus.tbst) begin
      bad = bus.ci || bus.wt; // [RULE5] [RULE8]
    end else if (bus.tsiz == `CPB_SZ_DWORD) begin
      bad = bus.addr[2:0] != 3'h0; // [RULE7]
    end else begin
      bad = bus.tsiz == 4'h0 || bus.tsiz > `CPB_SZ_WORD || lane + bus.tsiz > lanes; // [RULE3]
    end
  end

  // Snoop wins over a new core grant when both are pending
  always_comb begin
    nxt_a = a_ff;
    nxt_bg = bg_ff;
    nxt_aack = aack_ff;
    nxt_snp = snp_ff;
    nxt_sna = sna_ff;
    nxt_snw = snw_ff;
    nxt_pack = 1'b0;
    nxt_aon = 1'b0;
    push = 1'b0;
    nxt_wp = wp_ff;
    if (bus.bus_ce) begin
      unique case (a_ff)
        CPB_A_IDLE: if (pci_req && !pack_ff && snoop_en) begin
          nxt_snp = 1'b1; // [RULE12]
          nxt_sna = pci_addr;
          nxt_snw = pci_wr;
          nxt_a = CPB_A_SNOOP;
        end else if (pci_req && !pack_ff) begin
          nxt_pack = 1'b1;
        end else if (bus.br && !full) begin
          nxt_bg = 1'b1; // [RULE14]
          nxt_a = CPB_A_GRANT;
        end
        CPB_A_GRANT: if (bus.ts) begin
          nxt_bg = 1'b0;
          nxt_aack = 1'b1; // [RULE2]
          push = bus.tt != CPB_TT_AONLY; // [RULE11]
          nxt_aon = bus.tt == CPB_TT_AONLY;
          nxt_wp = push ? wp_ff + 1'b1 : wp_ff; // [RULE10]
          nxt_a = CPB_A_ACK;
        end
        CPB_A_ACK: begin
          nxt_aack = 1'b0;
          nxt_a = CPB_A_IDLE;
        end
        CPB_A_SNOOP: begin
          nxt_snp = 1'b0;
          nxt_pack = 1'b1;
          nxt_a = CPB_A_IDLE;
        end
      endcase
    end
  end

  // Address registers and the in-order tenure queue
  always_ff @(posedge clk) begin
    if (rst) begin
      a_ff <= CPB_A_IDLE;
      bg_ff <= 1'b0;
      aack_ff <= 1'b0;
      snp_ff <= 1'b0;
      sna_ff <= 32'h0;
      snw_ff <= 1'b0;
      pack_ff <= 1'b0;
      aon_ff <= 1'b0;
      wp_ff <= '0;
    end else begin
      a_ff <= nxt_a;
      bg_ff <= nxt_bg;
      aack_ff <= nxt_aack;
      snp_ff <= nxt_snp;
      sna_ff <= nxt_sna;
      snw_ff <= nxt_snw;
      pack_ff <= nxt_pack;
      aon_ff <= nxt_aon;
      wp_ff <= nxt_wp;
    end
    if (push) begin
      q_addr[wp_ff[PW-1:0]] <= bus.addr;
      q_sz[wp_ff[PW-1:0]] <= bus.tsiz;
      q_beats[wp_ff[PW-1:0]] <= nbeats;
      q_wr[wp_ff[PW-1:0]] <= bus.tt == CPB_TT_WRITE;
      q_bst[wp_ff[PW-1:0]] <= bus.tbst;
      q_err[wp_ff[PW-1:0]] <= bad;
    end
  end

  // ****************************************
  // Data tenure
  // ****************************************
  cpb_dfsm_t d_ff, nxt_d;
  logic dbg_ff, nxt_dbg, ta_ff, nxt_ta, tea_ff, nxt_tea, got_ff, nxt_got, qack_ff, nxt_qack;
  logic [3:0] beat_ff, nxt_beat;
  logic [63:0] dr_ff, nxt_dr;
  logic [PW-1:0] h;
  logic [31:0] start;
  logic [15:0] mask;

  assign h = rp_ff[PW-1:0];

  // Each beat waits for memory, then shows ta for exactly one bus clock
  always_comb begin
    nxt_d = d_ff;
    nxt_dbg = dbg_ff;
    nxt_ta = ta_ff;
    nxt_tea = tea_ff;
    nxt_got = got_ff;
    nxt_beat = beat_ff;
    nxt_dr = dr_ff;
    nxt_rp = rp_ff;
    nxt_qack = qack_ff;
    if (mem_req && mem_ack) begin
      nxt_got = 1'b1;
      nxt_dr = wide_ff ? mem_rdata : {32'h0, mem_rdata[31:0]};
    end
    if (bus.bus_ce) begin
      nxt_qack = bus.qreq && a_ff == CPB_A_IDLE && d_ff == CPB_D_IDLE && wp_ff == rp_ff;
      unique case (d_ff)
        CPB_D_IDLE: if (wp_ff != rp_ff) begin
          nxt_dbg = 1'b1; // [RULE15]
          nxt_beat = 4'h0;
          nxt_d = CPB_D_GRANT;
        end
        CPB_D_GRANT: begin
          nxt_dbg = 1'b0;
          nxt_tea = q_err[h];
          nxt_d = q_err[h] ? CPB_D_END : CPB_D_BEAT;
        end
        CPB_D_BEAT: if (ta_ff) begin
          nxt_ta = 1'b0;
          nxt_beat = beat_ff + 4'h1;
          if (beat_ff == q_beats[h] - 4'h1) begin
            nxt_rp = rp_ff + 1'b1; // [RULE15]
            nxt_d = CPB_D_IDLE;
          end
        end else if (got_ff) begin
          nxt_ta = 1'b1; // [RULE3] [RULE7]
          nxt_got = 1'b0;
        end
        CPB_D_END: begin
          nxt_tea = 1'b0;
          nxt_rp = rp_ff + 1'b1;
          nxt_d = CPB_D_IDLE;
        end
      endcase
    end
  end

  // Data registers
  always_ff @(posedge clk) begin
    if (rst) begin
      d_ff <= CPB_D_IDLE;
      dbg_ff <= 1'b0;
      ta_ff <= 1'b0;
      tea_ff <= 1'b0;
      got_ff <= 1'b0;
      beat_ff <= 4'h0;
      dr_ff <= 64'h0;
      rp_ff <= '0;
      qack_ff <= 1'b0;
    end else begin
      d_ff <= nxt_d;
      dbg_ff <= nxt_dbg;
      ta_ff <= nxt_ta;
      tea_ff <= nxt_tea;
      got_ff <= nxt_got;
      beat_ff <= nxt_beat;
      dr_ff <= nxt_dr;
      rp_ff <= nxt_rp;
      qack_ff <= nxt_qack;
    end
  end

  // Beat address walks a line for bursts, a doubleword for double beats
  always_comb begin
    start = q_bst[h] ? (q_addr[h] & `CPB_LINE_MASK) : (q_addr[h] & `CPB_DBL_MASK); // [RULE6] [RULE9]
    mem_addr = q_addr[h];
    mask = 16'h0;
    if (q_beats[h] != `CPB_SINGLE) begin
      mem_addr = start + (wide_ff ? 32'({beat_ff, 3'b000}) : 32'({beat_ff, 2'b00}));
      mem_be = wide_ff ? 8'hFF : 8'h0F;
    end else begin
      mask = (16'h1 << q_sz[h]) - 16'h1;
      mask = mask << (wide_ff ? q_addr[h][2:0] : {1'b0, q_addr[h][1:0]});
      mem_be = mask[7:0]; // [RULE3] [RULE7]
    end
  end

  // Outputs
  assign mem_req = d_ff == CPB_D_BEAT && !got_ff && !ta_ff;
  assign mem_we = q_wr[h];
  assign mem_wdata = wide_ff ? bus.dw : {32'h0, bus.dw[31:0]};
  assign bus.bg = bg_ff;
  assign bus.aack = aack_ff;
  assign bus.dbg = dbg_ff;
  assign bus.dr = dr_ff;
  assign bus.ta = ta_ff;
  assign bus.tea = tea_ff;
  assign bus.snp_ts = snp_ff;
  assign bus.snp_addr = sna_ff;
  assign bus.snp_wr = snw_ff;
  assign bus.qack = qack_ff;
  assign pci_ack = pack_ff;
  assign aonly_seen = aon_ff;
  assign bus_err = tea_ff;
endmodule

// file: cpb_bus_regs.svh
// Constants for the core to peripheral logic bus: beat counts, masks, sizes.
// Assumes it is included by the package and by the bus property checks.
`ifndef CPB_BUS_REGS_SVH
`define CPB_BUS_REGS_SVH
`define CPB_SINGLE 4'h1
`define CPB_DOUBLE 4'h2
`define CPB_BURST64 4'h4
`define CPB_BURST32 4'h8
`define CPB_SZ_WORD 4'h4
`define CPB_SZ_DWORD 4'h8
`define CPB_LANES64 4'h8
`define CPB_LANES32 4'h4
`define CPB_LINE_MASK 32'hFFFF_FFE0
`define CPB_DBL_MASK 32'hFFFF_FFF8
`define CPB_QDEPTH 2
`define CPB_BUS_DIV 1
`endif

// file: cpb_pkg.sv
// Types shared by both ends of the core to peripheral logic bus.
// Assumes cpb_bus_regs.svh sits in the same folder.
`include "cpb_bus_regs.svh"
package cpb_pkg;
  // Transfer type carried with each address tenure
  typedef enum logic [1:0] {
    CPB_TT_READ = 2'h0,
    CPB_TT_WRITE = 2'h1,
    CPB_TT_AONLY = 2'h2
  } cpb_tt_t;

  // Peripheral side address tenure states, Gray along idle-grant-ack
  typedef enum logic [1:0] {
    CPB_A_IDLE = 2'b00,
    CPB_A_GRANT = 2'b01,
    CPB_A_ACK = 2'b11,
    CPB_A_SNOOP = 2'b10
  } cpb_afsm_t;

  // Peripheral side data tenure states
  typedef enum logic [1:0] {
    CPB_D_IDLE = 2'b00,
    CPB_D_GRANT = 2'b01,
    CPB_D_BEAT = 2'b11,
    CPB_D_END = 2'b10
  } cpb_dfsm_t;

  // Core side address tenure states
  typedef enum logic [1:0] {
    CPB_C_IDLE = 2'b00,
    CPB_C_REQ = 2'b01,
    CPB_C_START = 2'b11,
    CPB_C_WAIT = 2'b10
  } cpb_cfsm_t;

  // Beats in one data tenure for the selected width
  function automatic logic [3:0] cpb_beats(input logic w64, input logic bst, input logic [3:0] sz);
    logic [3:0] n;
    n = `CPB_SINGLE;
    if (bst) begin
      n = w64 ? `CPB_BURST64 : `CPB_BURST32;
    end else if (!w64 && sz == `CPB_SZ_DWORD) begin
      n = `CPB_DOUBLE;
    end
    return n;
  endfunction
endpackage

// file: cpb_if.sv
// Signal bundle between the core end and the peripheral logic end.
// Assumes both ends share clk; bus_ce marks each bus clock.
`timescale 1ns/1ps
interface cpb_if;
  import cpb_pkg::*;
  // Bus clock enable from the peripheral side divider
  logic bus_ce;
  // Address arbitration and start
  logic br;
  logic bg;
  logic ts;
  // Address transfer and attributes
  logic [31:0] addr;
  cpb_tt_t tt;
  logic [3:0] tsiz;
  logic tbst;
  logic ci;
  logic wt;
  // Address termination
  logic aack;
  // Data arbitration, transfer and termination
  logic dbg;
  logic [63:0] dw;
  logic [63:0] dr;
  logic ta;
  logic tea;
  // Snoop of PCI memory accesses
  logic snp_ts;
  logic [31:0] snp_addr;
  logic snp_wr;
  // Processor state
  logic qreq;
  logic qack;

  modport dev (output bus_ce, bg, aack, dbg, dr, ta, tea, snp_ts, snp_addr, snp_wr, qack,
               input br, ts, addr, tt, tsiz, tbst, ci, wt, dw, qreq);
  modport core (input bus_ce, bg, aack, dbg, dr, ta, tea, snp_ts, snp_addr, snp_wr, qack,
                output br, ts, addr, tt, tsiz, tbst, ci, wt, dw, qreq);
endinterface

// file: cpb_core.sv
// Core end of the bus: turns user requests into address and data tenures.
// Assumes the peripheral end drives bus_ce and answers on the same clk.
`timescale 1ns/1ps
module cpb_core #(
  parameter int QD = `CPB_QDEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Width strap, sampled while in reset
  input wire logic strap_wide64,
  // Bus
  cpb_if.core bus,
  // User requests
  input wire logic req_valid,
  output logic req_ready,
  input wire cpb_pkg::cpb_tt_t req_kind,
  input wire logic [31:0] req_addr,
  input wire logic [3:0] req_size,
  input wire logic req_cached,
  input wire logic req_wt,
  // Write data and read data
  input wire logic [63:0] wr_data,
  output logic wr_next,
  output logic rd_valid,
  output logic [63:0] rd_data,
  output logic done,
  output logic err,
  // Snoop and state
  output logic snoop_valid,
  output logic [31:0] snoop_addr,
  output logic snoop_wr,
  input wire logic sleep_req,
  output logic sleep_ack
);
  import cpb_pkg::*;
  localparam int PW = $clog2(QD);

  logic wide_ff;
  cpb_cfsm_t c_ff, nxt_c;
  logic br_ff, nxt_br, ts_ff, nxt_ts, tbst_ff, nxt_tbst, ci_ff, nxt_ci, wt_ff, nxt_wt;
  logic [31:0] addr_ff, nxt_addr;
  cpb_tt_t tt_ff, nxt_tt;
  logic [3:0] tsiz_ff, nxt_tsiz;
  logic done_a_ff, nxt_done_a, push;
  logic [PW:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic q_wr [QD];
  logic [3:0] q_beats [QD];
  logic full, act_ff, nxt_act, done_d_ff, nxt_done_d, err_ff, nxt_err;
  logic nxt_wrn, rdv_ff, nxt_rdv, snv_ff, nxt_snv, snw_ff, nxt_snw;
  logic [3:0] beat_ff, nxt_beat;
  logic [63:0] rd_ff, nxt_rd, dw_ff, nxt_dw;
  logic [31:0] sna_ff, nxt_sna;

  assign full = (wp_ff - rp_ff) == (PW + 1)'(QD);
  assign req_ready = bus.bus_ce && c_ff == CPB_C_IDLE && !full;

  // ****************************************
  // Address tenure
  // ****************************************
  // Caching policy picks burst; otherwise size picks single or double beats
  always_comb begin
    nxt_c = c_ff;
    nxt_br = br_ff;
    nxt_ts = ts_ff;
    nxt_addr = addr_ff;
    nxt_tt = tt_ff;
    nxt_tsiz = tsiz_ff;
    nxt_tbst = tbst_ff;
    nxt_ci = ci_ff;
    nxt_wt = wt_ff;
    nxt_done_a = 1'b0;
    push = 1'b0;
    nxt_wp = wp_ff;
    unique case (c_ff)
      CPB_C_IDLE: if (req_valid && req_ready) begin
        nxt_addr = req_addr;
        nxt_tt = req_kind;
        nxt_tbst = req_cached && !req_wt && req_kind != CPB_TT_AONLY; // [RULE5] [RULE8] [RULE6] [RULE9]
        nxt_tsiz = nxt_tbst ? `CPB_SZ_DWORD : req_size; // [RULE3] [RULE7]
        nxt_ci = !req_cached;
        nxt_wt = req_wt;
        nxt_br = 1'b1; // [RULE14]
        nxt_c = CPB_C_REQ;
      end
      CPB_C_REQ: if (bus.bus_ce && bus.bg) begin
        nxt_br = 1'b0;
        nxt_ts = 1'b1; // [RULE2]
        nxt_c = CPB_C_START;
      end
      CPB_C_START: if (bus.bus_ce) begin
        nxt_ts = 1'b0;
        nxt_c = CPB_C_WAIT;
      end
      CPB_C_WAIT: if (bus.bus_ce && bus.aack) begin
        push = tt_ff != CPB_TT_AONLY; // [RULE11]
        nxt_done_a = tt_ff == CPB_TT_AONLY;
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff; // [RULE10]
        nxt_c = CPB_C_IDLE;
      end
    endcase
  end

  // Address registers; strap is latched for the whole run
  always_ff @(posedge clk) begin
    if (rst) begin
      wide_ff <= strap_wide64; // [RULE1]
      c_ff <= CPB_C_IDLE;
      br_ff <= 1'b0;
      ts_ff <= 1'b0;
      addr_ff <= 32'h0;
      tt_ff <= CPB_TT_READ;
      tsiz_ff <= 4'h0;
      tbst_ff <= 1'b0;
      ci_ff <= 1'b0;
      wt_ff <= 1'b0;
      done_a_ff <= 1'b0;
      wp_ff <= '0;
    end else begin
      c_ff <= nxt_c;
      br_ff <= nxt_br;
      ts_ff <= nxt_ts;
      addr_ff <= nxt_addr;
      tt_ff <= nxt_tt;
      tsiz_ff <= nxt_tsiz;
      tbst_ff <= nxt_tbst;
      ci_ff <= nxt_ci;
      wt_ff <= nxt_wt;
      done_a_ff <= nxt_done_a;
      wp_ff <= nxt_wp;
    end
    if (push) begin
      q_wr[wp_ff[PW-1:0]] <= tt_ff == CPB_TT_WRITE;
      q_beats[wp_ff[PW-1:0]] <= cpb_beats(wide_ff, tbst_ff, tsiz_ff);
    end
  end

  // ****************************************
  // Data tenure
  // ****************************************
  // Beats are counted only after a grant, head of queue first
  always_comb begin
    nxt_act = act_ff;
    nxt_beat = beat_ff;
    nxt_rp = rp_ff;
    nxt_done_d = 1'b0;
    nxt_err = 1'b0;
    nxt_wrn = 1'b0;
    nxt_rdv = 1'b0;
    nxt_rd = rd_ff;
    nxt_snv = 1'b0;
    nxt_sna = sna_ff;
    nxt_snw = snw_ff;
    nxt_dw = q_wr[rp_ff[PW-1:0]] ? wr_data : 64'h0;
    if (bus.bus_ce) begin
      if (bus.dbg && wp_ff != rp_ff) begin
        nxt_act = 1'b1; // [RULE15]
        nxt_beat = 4'h0;
      end else if (act_ff && bus.tea) begin
        nxt_act = 1'b0;
        nxt_rp = rp_ff + 1'b1;
        nxt_err = 1'b1;
      end else if (act_ff && bus.ta) begin
        nxt_wrn = q_wr[rp_ff[PW-1:0]];
        nxt_rdv = !q_wr[rp_ff[PW-1:0]];
        nxt_rd = bus.dr;
        nxt_beat = beat_ff + 4'h1;
        if (beat_ff == q_beats[rp_ff[PW-1:0]] - 4'h1) begin
          nxt_act = 1'b0; // [RULE15]
          nxt_rp = rp_ff + 1'b1;
          nxt_done_d = 1'b1;
        end
      end
      if (bus.snp_ts) begin
        nxt_snv = 1'b1;
        nxt_sna = bus.snp_addr;
        nxt_snw = bus.snp_wr;
      end
    end
  end

  // Data registers
  always_ff @(posedge clk) begin
    if (rst) begin
      act_ff <= 1'b0;
      beat_ff <= 4'h0;
      rp_ff <= '0;
      done_d_ff <= 1'b0;
      err_ff <= 1'b0;
      rdv_ff <= 1'b0;
      rd_ff <= 64'h0;
      snv_ff <= 1'b0;
      sna_ff <= 32'h0;
      snw_ff <= 1'b0;
      dw_ff <= 64'h0;
    end else begin
      act_ff <= nxt_act;
      beat_ff <= nxt_beat;
      rp_ff <= nxt_rp;
      done_d_ff <= nxt_done_d;
      err_ff <= nxt_err;
      rdv_ff <= nxt_rdv;
      rd_ff <= nxt_rd;
      snv_ff <= nxt_snv;
      sna_ff <= nxt_sna;
      snw_ff <= nxt_snw;
      dw_ff <= nxt_dw;
    end
  end

  // Bus and user outputs
  assign bus.br = br_ff;
  assign bus.ts = ts_ff;
  assign bus.addr = addr_ff;
  assign bus.tt = tt_ff;
  assign bus.tsiz = tsiz_ff;
  assign bus.tbst = tbst_ff;
  assign bus.ci = ci_ff;
  assign bus.wt = wt_ff;
  assign bus.dw = dw_ff;
  assign bus.qreq = sleep_req;
  assign sleep_ack = bus.qack;
  assign wr_next = nxt_wrn; // Unregistered, so next beat data reaches dw before memory can acknowledge that beat
  assign rd_valid = rdv_ff;
  assign rd_data = rd_ff;
  assign done = done_a_ff | done_d_ff;
  assign err = err_ff;
  assign snoop_valid = snv_ff;
  assign snoop_addr = sna_ff;
  assign snoop_wr = snw_ff;
endmodule

// file: cpb_bus_properties.sv
// Concurrent checks on the bus between the core end and the peripheral end.
// Assumes BUS_DIV of 1, so every clk edge is a bus clock.
`timescale 1ns/1ps
`include "cpb_bus_regs.svh"
module cpb_bus_properties
  import cpb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Address tenure
  input wire logic br,
  input wire logic bg,
  input wire logic ts,
  input wire cpb_pkg::cpb_tt_t tt,
  input wire logic [3:0] tsiz,
  input wire logic tbst,
  input wire logic ci,
  input wire logic wt,
  input wire logic aack,
  // Data tenure and snoop
  input wire logic dbg,
  input wire logic ta,
  input wire logic tea,
  input wire logic snp_ts
);
  // ****************
  // Properties
  // ****************
  // One domain; reset masks every check so stale $past values never count
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_grant_needs_req: assert property (bg |-> $past(br))
    else $error("address grant without a request");
  a_start_after_grant: assert property ($rose(ts) |-> $past(bg))
    else $error("address start without a grant");
  a_ack_follows_start: assert property (ts |=> aack)
    else $error("address start not acknowledged next bus clock");
  a_start_one_clock: assert property (ts |=> !ts)
    else $error("address start longer than one bus clock");
  a_ack_one_clock: assert property (aack |=> !aack)
    else $error("address acknowledge longer than one bus clock");
  // A burst always moves a whole line, so it is never noncached
  a_burst_attrs: assert property (ts && tbst |-> !ci && !wt && tsiz == `CPB_SZ_DWORD)
    else $error("burst with noncached attributes or wrong size");
  a_aonly_no_burst: assert property (ts && tt == CPB_TT_AONLY |-> !tbst)
    else $error("address-only transfer marked as burst");
  a_term_exclusive: assert property (!(ta && tea))
    else $error("beat acknowledge and error together");
  a_dgrant_one_clock: assert property (dbg |=> !dbg)
    else $error("data grant longer than one bus clock");
  a_snoop_one_clock: assert property (snp_ts |=> !snp_ts)
    else $error("snoop start longer than one bus clock");

  // Main scenarios
  c_aonly: cover property (ts && tt == CPB_TT_AONLY);
  c_burst: cover property (ts && tbst);
  c_snoop: cover property (snp_ts);
  c_error: cover property (tea);
endmodule

// file: test_core_peripheral_bus_interface.sv
// Self-checking bench: core end and peripheral end joined by one cpb_if.
// Assumes default BUS_DIV and queue depth; the bench plays memory and PCI.
`timescale 1ns/1ps
module test_core_peripheral_bus_interface;
  import cpb_pkg::*;
  // ****************
  // Signals
  // ****************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic strap_wide64 = 1'b0;
  logic req_valid = 1'b0;
  cpb_tt_t req_kind = CPB_TT_READ;
  logic [31:0] req_addr = 32'h0;
  logic [3:0] req_size = 4'h4;
  logic req_cached = 1'b0;
  logic req_wt = 1'b0;
  logic [63:0] wr_data = 64'h0;
  logic req_ready, wr_next, rd_valid, done, err, snoop_valid, snoop_wr, sleep_ack;
  logic [63:0] rd_data;
  logic [31:0] snoop_addr;
  logic snoop_en = 1'b0;
  logic sleep_req = 1'b0;
  logic pci_req = 1'b0;
  logic [31:0] pci_addr = 32'h0;
  logic pci_wr = 1'b0;
  logic mem_ack = 1'b0;
  logic [63:0] mem_rdata = 64'h0;
  logic pci_ack, mem_req, mem_we, aonly_seen, bus_err;
  logic [31:0] mem_addr;
  logic [7:0] mem_be;
  logic [63:0] mem_wdata;
  // Expectations of the transfer in flight; one at a time keeps them simple
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int nb, nr, nw, ao, sn, step;
  logic [31:0] base, amask;
  logic [63:0] dmask;
  logic [7:0] ebe;
  logic wr_op;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  cpb_if cpb_if_inst ();
  cpb_core cpb_core_inst (.clk, .rst, .strap_wide64, .bus(cpb_if_inst), .req_valid, .req_ready, .req_kind,
    .req_addr, .req_size, .req_cached, .req_wt, .wr_data, .wr_next, .rd_valid, .rd_data, .done, .err,
    .snoop_valid, .snoop_addr, .snoop_wr, .sleep_req, .sleep_ack);
  cpb_dev cpb_dev_inst (.clk, .rst, .strap_wide64, .bus(cpb_if_inst), .snoop_en, .pci_req, .pci_addr,
    .pci_wr, .pci_ack, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_ack, .mem_rdata,
    .aonly_seen, .bus_err);
  cpb_bus_properties cpb_bus_properties_inst (.clk, .rst, .br(cpb_if_inst.br), .bg(cpb_if_inst.bg),
    .ts(cpb_if_inst.ts), .tt(cpb_if_inst.tt), .tsiz(cpb_if_inst.tsiz), .tbst(cpb_if_inst.tbst),
    .ci(cpb_if_inst.ci), .wt(cpb_if_inst.wt), .aack(cpb_if_inst.aack), .dbg(cpb_if_inst.dbg),
    .ta(cpb_if_inst.ta), .tea(cpb_if_inst.tea), .snp_ts(cpb_if_inst.snp_ts));

  // ****************
  // Expectation helpers
  // ****************
  function automatic logic [63:0] rdpat(input logic [31:0] a);
    return {2{a ^ 32'h5A5A_A5A5}};
  endfunction
  function automatic logic [63:0] wpat(input int i);
    return {2{32'hC0DE_0000 + i[31:0]}};
  endfunction
  // Beats per data tenure from width, kind, caching attributes and size
  function automatic int beats(input logic w, input cpb_tt_t k, input logic c, input logic t, input logic [3:0] s);
    if (k == CPB_TT_AONLY) return 0;
    if (c && !t) return w ? 4 : 8;
    return (!w && s == 4'h8) ? 2 : 1;
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************
  // Memory, beat and timeout monitor
  // ****************
  // Memory answers after a random stall; data derives from the beat address
  always @(posedge clk) begin
    cyc <= cyc + 1;
    mem_ack <= mem_req && !mem_ack && ($urandom % 3 == 0);
    mem_rdata <= rdpat(mem_addr & amask);
    if (mem_req && mem_ack) begin
      chk(64'(mem_addr & amask), 64'(base + nb * step));
      chk(64'(mem_be), 64'(ebe));
      chk(64'(mem_we), 64'(wr_op));
      if (wr_op) chk(mem_wdata & dmask, wpat(nb) & dmask);
      nb++;
    end
    if (rd_valid) begin
      chk(rd_data & dmask, rdpat(base + nr * step) & dmask);
      nr++;
    end
    if (wr_next) begin
      nw = nw + 1;
      wr_data <= wpat(nw);
    end
    if (aonly_seen || bus_err) ao++;
    if (snoop_valid) begin
      chk(64'(snoop_addr), 64'(pci_addr));
      chk(64'(snoop_wr), 64'(pci_wr));
      sn++;
    end
    if (cyc == 30000) begin
      bad_count++;
      conclude();
    end
  end

  // ****************
  // Transfer tasks
  // ****************
  // One core request run to completion; bad marks a transfer the device must refuse
  task automatic xfer(input cpb_tt_t k, input logic [31:0] a, input logic [3:0] s, input logic c,
                      input logic t, input logic bad);
    int n;
    logic [15:0] m;
    n = bad ? 0 : beats(strap_wide64, k, c, t, s);
    nb = 0;
    nr = 0;
    nw = 0;
    ao = 0;
    wr_op = (k == CPB_TT_WRITE);
    step = strap_wide64 ? 8 : 4;
    base = (c && !t) ? (a & `CPB_LINE_MASK) : (a & amask);
    m = ((16'h1 << s) - 16'h1) << (strap_wide64 ? a[2:0] : {1'b0, a[1:0]});
    ebe = (n > 1) ? (strap_wide64 ? 8'hFF : 8'h0F) : m[7:0];
    @(posedge clk);
    req_valid <= 1'b1;
    req_kind <= k;
    req_addr <= a;
    req_size <= s;
    req_cached <= c;
    req_wt <= t;
    wr_data <= wpat(0);
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge clk); while (done !== 1'b1 && err !== 1'b1);
    chk(64'(err), 64'(bad));
    repeat (2) @(posedge clk);
    chk(nb, n);
    chk(nr, (k == CPB_TT_READ) ? n : 0);
    chk(ao, (k == CPB_TT_AONLY || bad) ? 1 : 0);
  endtask

  task automatic snoop(input logic e, input logic [31:0] a);
    sn = 0;
    @(posedge clk);
    snoop_en <= e;
    pci_req <= 1'b1;
    pci_addr <= a;
    pci_wr <= a[6];
    do @(posedge clk); while (pci_ack !== 1'b1);
    pci_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk(sn, e ? 1 : 0);
  endtask

  // ****************
  // Main sequence: 32-bit width, then 64-bit width after a fresh reset
  // ****************
  initial begin
    logic [3:0] szs [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h8};
    logic [31:0] a;
    logic [3:0] s;
    int lw;
    void'($urandom(32'hA193));
    for (int md = 0; md < 2; md++) begin
      rst <= 1'b1;
      strap_wide64 <= md[0];
      amask = md[0] ? 32'hFFFF_FFF8 : 32'hFFFF_FFFC;
      dmask = md[0] ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      xfer(CPB_TT_AONLY, 32'h0000_1000, 4'h4, 1'b0, 1'b0, 1'b0);
      xfer(CPB_TT_READ, 32'h0000_2014, 4'h8, 1'b1, 1'b0, 1'b0);
      xfer(CPB_TT_WRITE, 32'h0000_3000, 4'h8, 1'b1, 1'b0, 1'b0);
      xfer(CPB_TT_WRITE, 32'h0000_4008, 4'h8, 1'b1, 1'b1, 1'b0);
      xfer(CPB_TT_READ, 32'h0000_5001, 4'h3, 1'b0, 1'b0, 1'b0);
      xfer(CPB_TT_READ, 32'h0000_6000, 4'h5, 1'b0, 1'b0, 1'b1);
      snoop(1'b1, 32'h0000_7040);
      snoop(1'b0, 32'h0000_7080);
      // Processor state handshake while the bus is idle
      sleep_req <= 1'b1;
      repeat (2) @(posedge clk);
      chk(64'(sleep_ack), 64'h1);
      sleep_req <= 1'b0;
      repeat (2) @(posedge clk);
      chk(64'(sleep_ack), 64'h0);
      // Random traffic with legal sizes placed inside one lane group
      lw = md[0] ? 8 : 4;
      for (int i = 0; i < 20; i++) begin
        s = szs[$urandom % 5];
        a = $urandom;
        a = (s == 4'h8) ? (a & 32'hFFFF_FFF8) : ((a & amask) + 32'($urandom % (lw - s + 1)));
        xfer(cpb_tt_t'($urandom % 3), a, s, 1'($urandom), 1'($urandom), 1'b0);
      end
    end
    conclude();
  end
endmodule
